// >>> verilog/cfr_defs.svh
// constants for the current fault retry control core
// assumes one oscillator tick per enabled clock, timing scaled by tick period
`ifndef CFR_DEFS_SVH
`define CFR_DEFS_SVH
// times in microseconds at default timing capacitor
`define CFR_FLT_US 1550
`define CFR_POR_US 1550
`define CFR_LIMITON_US 12800
`define CFR_OFF_US 410000
`define CFR_CLK_MHZ 40
`define CFR_FLT_CYC (`CFR_FLT_US * `CFR_CLK_MHZ)
`define CFR_POR_CYC (`CFR_POR_US * `CFR_CLK_MHZ)
`define CFR_LIMITON_CYC (`CFR_LIMITON_US * `CFR_CLK_MHZ)
`define CFR_OFF_CYC (`CFR_OFF_US * `CFR_CLK_MHZ)
`define CFR_FAULT_LIMIT 7
`define CFR_CLEAR_MULT 2
`define CFR_CNT_W 32
`endif

// >>> verilog/cfr_pkg.sv
// types for the current fault retry control core
// assumes cfr_defs.svh supplies the numeric constants
package cfr_pkg;
  typedef enum logic [2:0] {
    CFR_IDLE = 3'b000,
    CFR_POR = 3'b001,
    CFR_ON = 3'b010,
    CFR_OFF = 3'b011,
    CFR_LATCH = 3'b100
  } cfr_state_t;
  typedef struct packed {
    logic window;
    logic breaker;
    logic analogLimit;
    logic fastLimit;
    logic faultClear;
  } cfr_sense_t;
  typedef struct packed {
    logic gateEnable;
    logic regulate;
    logic fastPull;
    logic latched;
  } cfr_drive_t;
endpackage : cfr_pkg

// >>> verilog/cfr_window_filter.sv
// supply window glitch filter, filters only the faulting edge
// assumes input already synchronised to clk
`timescale 1ns/1ps
module cfr_window_filter #(
  parameter int FLT_CYC = 62000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic inWindow,
  output logic windowOk
);
  initial begin
    if (FLT_CYC < 1) $error("filter count too small");
  end
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_windowOk;
  always_comb begin
    next_cnt = 32'h0;
    next_windowOk = windowOk;
    if (inWindow) begin
      next_windowOk = 1'b1;
    end else if (windowOk) begin
      next_cnt = cnt + 32'h1;
      if (cnt >= FLT_CYC - 1) begin
        next_windowOk = 1'b0;
        next_cnt = 32'h0;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 32'h0;
      windowOk <= 1'b0;
    end else if (ce) begin
      cnt <= next_cnt;
      windowOk <= next_windowOk;
    end
  end
endmodule : cfr_window_filter

// >>> verilog/cfr_core.sv
// current fault retry control core: gate drive supervision
// assumes comparator inputs are asynchronous, nrst comes from supply lockout
`timescale 1ns/1ps
`include "cfr_defs.svh"
module cfr_core
  import cfr_pkg::*;
#(
  parameter int FLT_CYC = `CFR_FLT_CYC,
  parameter int POR_CYC = `CFR_POR_CYC,
  parameter int LIMITON_CYC = `CFR_LIMITON_CYC,
  parameter int OFF_CYC = `CFR_OFF_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire cfr_sense_t senseIn,
  output cfr_drive_t drive,
  output logic [2:0] faultCount
);
  initial begin
    if (LIMITON_CYC < 1 || OFF_CYC < LIMITON_CYC || POR_CYC < 1) $error("bad timing parameters");
    if (`CFR_CLEAR_MULT * OFF_CYC > 32'h7FFFFFFF) $error("clear window too long");
  end
  localparam logic [31:0] CLEAR_CYC = 32'(`CFR_CLEAR_MULT * OFF_CYC);
  localparam logic [2:0] FAULT_LIMIT = 3'(`CFR_FAULT_LIMIT);

  // two stage synchronisers for asynchronous comparator levels
  cfr_sense_t syncA;
  cfr_sense_t syncB;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncA <= '0;
      syncB <= '0;
    end else if (ce) begin
      syncA <= senseIn;
      syncB <= syncA;
    end
  end

  logic windowOk;
  cfr_window_filter #(
    .FLT_CYC(FLT_CYC)
  ) uFilter (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .inWindow(syncB.window),
    .windowOk(windowOk)
  );

  cfr_state_t state;
  cfr_state_t next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [31:0] sinceTimeout;
  logic [31:0] next_sinceTimeout;
  logic windowArmed;
  logic next_windowArmed;
  logic faultPending;
  logic next_faultPending;
  logic [2:0] next_faultCount;
  cfr_drive_t next_drive;

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_sinceTimeout = sinceTimeout;
    next_windowArmed = windowArmed;
    next_faultPending = faultPending;
    next_faultCount = faultCount;
    // clearing window runs from each limit-on timeout
    if (windowArmed) begin
      next_sinceTimeout = sinceTimeout + 32'h1;
      if (sinceTimeout >= CLEAR_CYC - 32'h1 && state != CFR_LATCH) begin
        next_faultCount = 3'h0;
        next_windowArmed = 1'b0;
      end
    end
    // a fault still counts until clear comparator confirms low current
    if (syncB.faultClear) begin
      next_faultPending = 1'b0;
    end
    unique case (state)
      CFR_IDLE: begin
        next_timer = 32'h0;
        if (windowOk) begin
          next_state = CFR_POR;
        end
      end
      CFR_POR: begin
        next_timer = timer + 32'h1;
        if (!windowOk) begin
          next_state = CFR_IDLE;
          next_timer = 32'h0;
        end else if (timer >= 32'(POR_CYC) - 32'h1) begin
          next_state = CFR_ON;
          next_timer = 32'h0;
        end
      end
      CFR_ON: begin
        if (!windowOk) begin
          next_state = CFR_IDLE;
          next_timer = 32'h0;
        end else if (syncB.breaker) begin
          next_timer = timer + 32'h1;
          if (timer >= 32'(LIMITON_CYC) - 32'h1) begin
            // fault registered at end of limit-on interval
            next_timer = 32'h0;
            next_sinceTimeout = 32'h0;
            next_windowArmed = 1'b1;
            next_faultPending = 1'b1;
            if (faultCount + 3'h1 >= FAULT_LIMIT && (faultPending || faultCount == 3'h0 || windowArmed)) begin
              next_faultCount = FAULT_LIMIT;
              next_state = CFR_LATCH;
            end else begin
              next_faultCount = faultCount + 3'h1;
              next_state = CFR_OFF;
            end
          end
        end else begin
          next_timer = 32'h0;
        end
      end
      CFR_OFF: begin
        next_timer = timer + 32'h1;
        if (timer >= 32'(OFF_CYC) - 32'h1) begin
          next_timer = 32'h0;
          next_state = windowOk ? CFR_ON : CFR_IDLE;
        end
      end
      CFR_LATCH: begin
        next_timer = 32'h0;
      end
      default: begin
        next_state = CFR_LATCH;
        next_timer = 32'h0;
      end
    endcase
    next_drive.latched = (next_state == CFR_LATCH);
    next_drive.gateEnable = (next_state == CFR_ON) && windowOk;
    // regulation loop stays on while limited inside limit-on, not switched off
    next_drive.regulate = next_drive.gateEnable && syncB.analogLimit;
    // fast path bypasses the timers: short circuits cannot wait
    next_drive.fastPull = syncB.fastLimit || !next_drive.gateEnable;
  end

  // asynchronous lockout reset restores all counters and timers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= CFR_IDLE;
      timer <= 32'h0;
      sinceTimeout <= 32'h0;
      windowArmed <= 1'b0;
      faultPending <= 1'b0;
      faultCount <= 3'h0;
      drive <= '{gateEnable: 1'b0, regulate: 1'b0, fastPull: 1'b1, latched: 1'b0};
    end else if (ce) begin
      state <= next_state;
      timer <= next_timer;
      sinceTimeout <= next_sinceTimeout;
      windowArmed <= next_windowArmed;
      faultPending <= next_faultPending;
      faultCount <= next_faultCount;
      drive <= next_drive;
    end
  end
  // limit-on and off counts share one clock, so their ratio is set at build time only
endmodule : cfr_core

// >>> bench/cfr_plant.sv
// far side: pass transistor plus sense comparators
// assumes bench sets load shunt level in mV and window level
`timescale 1ns/1ps
module cfr_plant
  import cfr_pkg::*;
(
  input wire cfr_drive_t drive,
  input wire logic win,
  input wire logic [7:0] loadMv,
  output cfr_sense_t senseIn
);
  logic [7:0] mv;
  // no current flows with the gate off
  assign mv = drive.gateEnable ? loadMv : 8'h00;
  assign senseIn.window = win;
  assign senseIn.breaker = mv >= 8'h58;
  assign senseIn.analogLimit = mv >= 8'h64;
  assign senseIn.fastLimit = mv >= 8'h7E;
  assign senseIn.faultClear = mv < 8'h4F;
endmodule : cfr_plant

// >>> bench/cfr_core_properties.sv
// timing checks on the fault retry core ports
// assumes ce driven by the bench, which holds it low for part of t_win
`timescale 1ns/1ps
module cfr_core_properties
  import cfr_pkg::*;
#(
  parameter int FLT_CYC = 4,
  parameter int LIMITON_CYC = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire cfr_sense_t senseIn,
  input wire cfr_drive_t drive,
  input wire logic [2:0] faultCount
);
  int brkRun;
  int winRun;
  int next_brkRun;
  int next_winRun;
  logic step;
  always_comb begin
    // run lengths freeze with the core while ce is low
    next_brkRun = !ce ? brkRun : (senseIn.breaker ? brkRun + 1 : 0);
    next_winRun = !ce ? winRun : (senseIn.window ? 0 : winRun + 1);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      brkRun <= 0;
      winRun <= 0;
    end else begin
      brkRun <= next_brkRun;
      winRun <= next_winRun;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_off_pulls_down: assert property (!drive.gateEnable |-> drive.fastPull) else $error("pull-down off");
  a_latch_holds: assert property (drive.latched |-> faultCount == 3'h7 && !drive.gateEnable) else $error("latch");
  a_latch_sticky: assert property (drive.latched |=> drive.latched) else $error("latch lost");
  a_count_step: assert property ($changed(faultCount) |-> faultCount == $past(faultCount) + 3'h1 || faultCount == 3'h0)
    else $error("count step");
  a_fault_timed: assert property (faultCount == $past(faultCount) + 3'h1 |-> brkRun >= LIMITON_CYC)
    else $error("early fault");
  a_off_hold: assert property (faultCount == $past(faultCount) + 3'h1 |=> !drive.gateEnable [*8])
    else $error("short off");
  a_window_off: assert property (winRun > FLT_CYC + 4 |-> !drive.gateEnable) else $error("window");
  a_fast_pull: assert property ($rose(senseIn.fastLimit) |-> ##[1:4] drive.fastPull) else $error("fast");
  c_latched: cover property (drive.latched);
  c_retry: cover property (faultCount == 3'h1 && drive.gateEnable);
  c_fast: cover property (drive.fastPull && drive.gateEnable);
endmodule : cfr_core_properties
bind cfr_core cfr_core_properties #(.FLT_CYC(FLT_CYC), .LIMITON_CYC(LIMITON_CYC)) u_props (.clk(clk), .nrst(nrst),
  .ce(ce), .senseIn(senseIn), .drive(drive), .faultCount(faultCount));

// >>> bench/tb_top.sv
// bench for the fault retry core with short timing
// assumes cfr_plant stands for the transistor and comparators
`timescale 1ns/1ps
module tb_top;
  import cfr_pkg::*;
  localparam int FLT = 4, POR = 4, LON = 10, OFF = 40;
  logic clk = 1'b0, nrst = 1'b0, win = 1'b0, ce = 1'b1;
  logic [7:0] loadMv = 8'h00;
  cfr_sense_t senseIn;
  cfr_drive_t drive;
  logic [2:0] faultCount;
  int n_errors = 0, checks_done = 0, i;
  initial begin
    forever #12.5 clk = ~clk;
  end
  cfr_core #(.FLT_CYC(FLT), .POR_CYC(POR), .LIMITON_CYC(LON), .OFF_CYC(OFF)) dut (.clk(clk), .nrst(nrst),
    .ce(ce), .senseIn(senseIn), .drive(drive), .faultCount(faultCount));
  cfr_plant plant (.drive(drive), .win(win), .loadMv(loadMv), .senseIn(senseIn));
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  // a used-up bound ends the run
  task lim(input int n);
    if (i >= n) begin
      n_errors++;
      give_verdict();
    end
  endtask : lim
  task rst;
    nrst <= 1'b0;
    ce <= 1'b1;
    win <= 1'b0;
    loadMv <= 8'h00;
    repeat (3) @(posedge clk);
    chk("gate", 4'h0, drive.gateEnable);
    chk("latch", 4'h0, drive.latched);
    chk("count", 4'h0, faultCount);
    nrst <= 1'b1;
    win <= 1'b1;
    for (i = 0; i < 40 && drive.gateEnable !== 1'b1; i++) @(posedge clk);
    lim(40);
  endtask : rst
  task t_retry;
    loadMv <= 8'h5A;
    for (i = 0; i < 40 && faultCount !== 3'h1; i++) @(posedge clk);
    lim(40);
    chk("ontime", 4'h1, i >= LON);
    chk("gate", 4'h0, drive.gateEnable);
    loadMv <= 8'h00;
    for (i = 0; i < 60 && drive.gateEnable !== 1'b1; i++) @(posedge clk);
    lim(60);
    chk("offlen", 4'h1, i >= OFF - 2);
  endtask : t_retry
  task t_clear;
    chk("count", 4'h1, faultCount);
    repeat (2 * OFF + 10) @(posedge clk);
    chk("cleared", 4'h0, faultCount);
    loadMv <= 8'h66;
    repeat (5) @(posedge clk);
    chk("regulate", 4'h1, drive.regulate);
    chk("gate", 4'h1, drive.gateEnable);
    loadMv <= 8'h00;
    repeat (4) @(posedge clk);
    chk("regoff", 4'h0, drive.regulate);
    chk("count", 4'h0, faultCount);
  endtask : t_clear
  task t_win;
    win <= 1'b0;
    repeat (2) @(posedge clk);
    win <= 1'b1;
    repeat (8) @(posedge clk);
    chk("glitch", 4'h1, drive.gateEnable);
    win <= 1'b0;
    repeat (FLT + 6) @(posedge clk);
    chk("winoff", 4'h0, drive.gateEnable);
    win <= 1'b1;
    for (i = 0; i < 30 && drive.gateEnable !== 1'b1; i++) @(posedge clk);
    lim(30);
    chk("return", 4'h1, i < POR + 6);
    // low enable must freeze the window filter and the gate
    ce <= 1'b0;
    win <= 1'b0;
    repeat (FLT + 6) @(posedge clk);
    chk("frozen", 4'h1, drive.gateEnable);
    ce <= 1'b1;
    win <= 1'b1;
    repeat (4) @(posedge clk);
    chk("thawed", 4'h1, drive.gateEnable);
  endtask : t_win
  task t_fast;
    loadMv <= 8'h82;
    for (i = 0; i < 8 && drive.fastPull !== 1'b1; i++) @(posedge clk);
    chk("fast", 4'h1, i < 6);
  endtask : t_fast
  task t_latch;
    loadMv <= 8'h5A;
    for (i = 0; i < 600 && drive.latched !== 1'b1; i++) @(posedge clk);
    lim(600);
    chk("count", 4'h7, faultCount);
    repeat (2 * OFF + 10) @(posedge clk);
    chk("held", 4'h1, drive.latched);
    chk("gate", 4'h0, drive.gateEnable);
  endtask : t_latch
  initial begin
    rst();
    t_retry();
    t_clear();
    t_win();
    t_fast();
    rst();
    t_latch();
    rst();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule : tb_top
